// File: tch_host.sv
// Two-wire bus host that runs transfers to the touch controller
//
// Function
// R01 - Both lines only pulled low or released; output value is always zero.
// R02 - Data line changes only while the clock line is low.
// R03 - START and STOP are data edges while clock is high; bus monitor sees them.
// R04 - Host alone opens and closes transfers; bus busy from START to STOP.
// R05 - Address byte is seven address bits, direction bit, acknowledge slot.
// R06 - Direction bit set means read, cleared means write.
// R07 - Address and data bytes go out most significant bit first.
// R08 - Device pulls data low in ninth period when its address matches.
// R09 - Device address comes from strap inputs; host sends that address.
// R10 - Each data byte is eight bits plus one acknowledge slot.
// R11 - Host makes every clock pulse and both START and STOP markers.
// R12 - Receiver acknowledges low in ninth period; high means not-acknowledge.
// R13 - Transfer is START, address byte, one or more data bytes, STOP.
// R14 - Device may hold clock low; host waits for clock really high.
// R15 - Every transfer closes with STOP, never a repeated START.
// R16 - Unmatched address leaves lines released; host sees no acknowledge.
`timescale 1ns/100ps
module tch_host #(
   parameter int LEN_W = tch_pkg::LEN_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [6:0] dev_addr,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_rw,
   input wire logic [LEN_W-1:0] cmd_len,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic done,
   output logic nack,
   output logic bus_busy,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   tch_ln_if ln ();

   tch_sync u_sync (
      .clock(clock),
      .rst(rst),
      .scl_pin(scl_i),
      .sda_pin(sda_i),
      .ln(ln.pins)
   );

   tch_timer #(
      .CYC(tch_pkg::QTR_CYC)
   ) u_timer (
      .clock(clock),
      .rst(rst),
      .ln(ln.tmr)
   );

   tch_pkg::tch_state_t state_q;
   tch_pkg::tch_state_t state_d;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic [LEN_W-1:0] left_q;
   logic [LEN_W-1:0] left_d;
   logic addr_ph_q;
   logic addr_ph_d;
   logic rw_q;
   logic rw_d;
   logic hcnt_q;
   logic hcnt_d;
   logic stop_q;
   logic stop_d;
   logic scl_oe_q;
   logic scl_oe_d;
   logic sda_oe_q;
   logic sda_oe_d;
   logic go_q;
   logic go_d;
   logic done_q;
   logic done_d;
   logic nack_q;
   logic nack_d;
   logic rxv_q;
   logic rxv_d;
   logic [7:0] rxd_q;
   logic [7:0] rxd_d;
   logic txr_q;
   logic txr_d;
   logic cmdr_q;
   logic cmdr_d;
   logic busy_q;
   logic busy_d;
   logic sda_prev_q;
   logic pin_o_q;

   // Decoded conditions
   logic tdone;
   logic scl_hi;
   logic sda_hi;
   logic tx_mode;
   logic last;
   logic is_ack;
   logic release_bit;
   logic start_seen;
   logic stop_seen;
   logic bus_free;
   logic take_cmd;
   logic [LEN_W-1:0] len_eff;

   assign tdone = ln.tmr_done;
   assign scl_hi = ln.scl_lvl;
   assign sda_hi = ln.sda_lvl;
   assign ln.tmr_go = go_q;
   // Direction bit set means device sends
   assign tx_mode = addr_ph_q | ~rw_q;
   assign last = (left_q == LEN_W'(1));
   assign is_ack = (bit_q == tch_pkg::ACK_BIT);
   // Receiver owns ack slot; host acks read bytes except the last
   assign release_bit = is_ack ? (tx_mode | last) : (~tx_mode | sh_q[7]);
   // Markers are data edges while clock is high
   assign start_seen = scl_hi & sda_prev_q & ~sda_hi;
   assign stop_seen = scl_hi & ~sda_prev_q & sda_hi;
   assign bus_free = ~busy_q & scl_hi & sda_hi;
   assign take_cmd = cmd_valid & cmdr_q;
   // Zero length still carries one data byte
   assign len_eff = (cmd_len == '0) ? LEN_W'(1) : cmd_len;

   // Bus occupancy from observed markers
   assign busy_d = start_seen ? 1'b1 : (stop_seen ? 1'b0 : busy_q);

   always_comb begin
      state_d = state_q;
      sh_d = sh_q;
      bit_d = bit_q;
      left_d = left_q;
      addr_ph_d = addr_ph_q;
      rw_d = rw_q;
      hcnt_d = hcnt_q;
      stop_d = stop_q;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      go_d = 1'b0;
      done_d = 1'b0;
      nack_d = nack_q;
      rxv_d = 1'b0;
      rxd_d = rxd_q;
      txr_d = 1'b0;
      unique case (state_q)
         tch_pkg::ST_IDLE: begin
            if (take_cmd) begin
               // R05 R09 address byte from straps
               sh_d = {dev_addr, cmd_rw};
               rw_d = cmd_rw;
               left_d = len_eff;
               addr_ph_d = 1'b1;
               bit_d = '0;
               stop_d = 1'b0;
               nack_d = 1'b0;
               // START: data falls while clock is high
               sda_oe_d = 1'b1;
               go_d = 1'b1;
               state_d = tch_pkg::ST_START_A;
            end
         end
         tch_pkg::ST_START_A: begin
            if (tdone) begin
               scl_oe_d = 1'b1;
               go_d = 1'b1;
               state_d = tch_pkg::ST_START_B;
            end
         end
         tch_pkg::ST_START_B: begin
            if (tdone) begin
               state_d = tch_pkg::ST_SETUP;
            end
         end
         tch_pkg::ST_LOAD: begin
            if (rw_q) begin
               sh_d = tch_pkg::RD_FILL;
               state_d = tch_pkg::ST_SETUP;
            end else if (tx_valid) begin
               sh_d = tx_data;
               txr_d = 1'b1;
               state_d = tch_pkg::ST_SETUP;
            end
         end
         tch_pkg::ST_SETUP: begin
            // R02 data set only while clock low
            sda_oe_d = ~release_bit;
            go_d = 1'b1;
            state_d = tch_pkg::ST_LOW;
         end
         tch_pkg::ST_LOW: begin
            if (tdone) begin
               scl_oe_d = 1'b0;
               state_d = tch_pkg::ST_HIGH_W;
            end
         end
         tch_pkg::ST_HIGH_W: begin
            // R11 R14 host clock waits high
            if (scl_hi) begin
               hcnt_d = 1'b0;
               go_d = 1'b1;
               state_d = tch_pkg::ST_HIGH;
            end
         end
         tch_pkg::ST_HIGH: begin
            if (tdone && !hcnt_q) begin
               hcnt_d = 1'b1;
               go_d = 1'b1;
            end else if (tdone) begin
               if (!is_ack) begin
                  // R07 shift most significant first
                  sh_d = {sh_q[6:0], sda_hi};
               end else if (tx_mode && sda_hi) begin
                  // R16 no acknowledge ends the transfer
                  nack_d = 1'b1;
                  stop_d = 1'b1;
               end else if (addr_ph_q) begin
                  addr_ph_d = 1'b0;
               end else begin
                  // R12 R13 byte closed, last stops
                  rxv_d = rw_q;
                  rxd_d = rw_q ? sh_q : rxd_q;
                  left_d = left_q - LEN_W'(1);
                  stop_d = last;
               end
               scl_oe_d = 1'b1;
               go_d = 1'b1;
               state_d = tch_pkg::ST_FALL;
            end
         end
         tch_pkg::ST_FALL: begin
            if (tdone && stop_q) begin
               // R15 close with STOP
               sda_oe_d = 1'b1;
               go_d = 1'b1;
               state_d = tch_pkg::ST_STOP_A;
            end else if (tdone && is_ack) begin
               // R10 next byte after nine periods
               bit_d = '0;
               state_d = tch_pkg::ST_LOAD;
            end else if (tdone) begin
               bit_d = bit_q + 4'h1;
               state_d = tch_pkg::ST_SETUP;
            end
         end
         tch_pkg::ST_STOP_A: begin
            if (tdone) begin
               scl_oe_d = 1'b0;
               state_d = tch_pkg::ST_STOP_W;
            end
         end
         tch_pkg::ST_STOP_W: begin
            // R14 stretch honoured before STOP
            if (scl_hi) begin
               go_d = 1'b1;
               state_d = tch_pkg::ST_STOP_B;
            end
         end
         tch_pkg::ST_STOP_B: begin
            if (tdone) begin
               // R03 data rises while clock high
               sda_oe_d = 1'b0;
               go_d = 1'b1;
               state_d = tch_pkg::ST_STOP_C;
            end
         end
         tch_pkg::ST_STOP_C: begin
            if (tdone) begin
               done_d = 1'b1;
               state_d = tch_pkg::ST_IDLE;
            end
         end
         default: begin
            scl_oe_d = 1'b0;
            sda_oe_d = 1'b0;
            state_d = tch_pkg::ST_IDLE;
         end
      endcase
   end

   // R04 new transfer only on a free bus
   assign cmdr_d = (state_d == tch_pkg::ST_IDLE) & ~take_cmd & bus_free & ~done_d;

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= tch_pkg::ST_IDLE;
         sh_q <= '0;
         bit_q <= '0;
         left_q <= '0;
         addr_ph_q <= 1'b0;
         rw_q <= 1'b0;
         hcnt_q <= 1'b0;
         stop_q <= 1'b0;
      end else begin
         state_q <= state_d;
         sh_q <= sh_d;
         bit_q <= bit_d;
         left_q <= left_d;
         addr_ph_q <= addr_ph_d;
         rw_q <= rw_d;
         hcnt_q <= hcnt_d;
         stop_q <= stop_d;
      end
   end

   // R01 pins only pulled low or released
   always_ff @(posedge clock) begin
      if (rst) begin
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         pin_o_q <= 1'b0;
         go_q <= 1'b0;
      end else begin
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         pin_o_q <= 1'b0;
         go_q <= go_d;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         done_q <= 1'b0;
         nack_q <= 1'b0;
         rxv_q <= 1'b0;
         rxd_q <= '0;
         txr_q <= 1'b0;
         cmdr_q <= 1'b0;
      end else begin
         done_q <= done_d;
         nack_q <= nack_d;
         rxv_q <= rxv_d;
         rxd_q <= rxd_d;
         txr_q <= txr_d;
         cmdr_q <= cmdr_d;
      end
   end

   // R03 bus monitor for markers
   always_ff @(posedge clock) begin
      if (rst) begin
         busy_q <= 1'b0;
         sda_prev_q <= tch_pkg::LINE_IDLE;
      end else begin
         busy_q <= busy_d;
         sda_prev_q <= sda_hi;
      end
   end

   assign cmd_ready = cmdr_q;
   assign tx_ready = txr_q;
   assign rx_valid = rxv_q;
   assign rx_data = rxd_q;
   assign done = done_q;
   assign nack = nack_q;
   assign bus_busy = busy_q;
   assign scl_o = pin_o_q;
   assign scl_oe = scl_oe_q;
   assign sda_o = pin_o_q;
   assign sda_oe = sda_oe_q;
endmodule

// File: tch_pkg.sv
// Shared constants and types for the touch controller bus host
package tch_pkg;

   // Clock period of the host logic in ns
   localparam int CLK_NS = 40;
   // One quarter of a 400 kHz bit period in ns
   localparam int QTR_NS = 625;
   // Quarter period in clock cycles, rounded up
   localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
   // Width of the quarter timer
   localparam int TMR_W = $clog2(QTR_CYC + 1);

   // Bit index of the acknowledge slot within a byte
   localparam logic [3:0] ACK_BIT = 4'h8;
   // Idle level of a released bus line
   localparam logic LINE_IDLE = 1'b1;
   // Value loaded into the shift register before reading
   localparam logic [7:0] RD_FILL = 8'hFF;
   // Default byte count width
   localparam int LEN_W = 8;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'h0,
      ST_START_A = 4'h1,
      ST_START_B = 4'h2,
      ST_LOAD    = 4'h3,
      ST_SETUP   = 4'h4,
      ST_LOW     = 4'h5,
      ST_HIGH_W  = 4'h6,
      ST_HIGH    = 4'h7,
      ST_FALL    = 4'h8,
      ST_STOP_A  = 4'h9,
      ST_STOP_W  = 4'hA,
      ST_STOP_B  = 4'hB,
      ST_STOP_C  = 4'hC
   } tch_state_t;

endpackage

// File: tch_ln_if.sv
// Internal carrier between pin synchroniser, quarter timer and host core
`timescale 1ns/100ps
interface tch_ln_if;
   logic scl_lvl;
   logic sda_lvl;
   logic tmr_go;
   logic tmr_done;

   modport pins (output scl_lvl, output sda_lvl);
   modport tmr (input tmr_go, output tmr_done);
   modport core (input scl_lvl, input sda_lvl, input tmr_done, output tmr_go);
endinterface

// File: tch_sync.sv
// Three-stage synchroniser for the two bus line inputs
`timescale 1ns/100ps
module tch_sync (
   input wire logic clock,
   input wire logic rst,
   input wire logic scl_pin,
   input wire logic sda_pin,
   tch_ln_if.pins ln
);
   logic [1:0] pin;
   logic [1:0] s1_q;
   logic [1:0] s2_q;
   logic [1:0] s3_q;
   logic [1:0] lvl_q;

   assign pin = {sda_pin, scl_pin};
   assign ln.scl_lvl = lvl_q[0];
   assign ln.sda_lvl = lvl_q[1];

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_line
         // Level changes only once stages two and three agree
         always_ff @(posedge clock) begin
            if (rst) begin
               s1_q[i] <= tch_pkg::LINE_IDLE;
               s2_q[i] <= tch_pkg::LINE_IDLE;
               s3_q[i] <= tch_pkg::LINE_IDLE;
               lvl_q[i] <= tch_pkg::LINE_IDLE;
            end else begin
               s1_q[i] <= pin[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i]) begin
                  lvl_q[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate
endmodule

// File: tch_timer.sv
// Quarter bit period timer, one done pulse per start
`timescale 1ns/100ps
module tch_timer #(
   parameter int CYC = tch_pkg::QTR_CYC
) (
   input wire logic clock,
   input wire logic rst,
   tch_ln_if.tmr ln
);
   logic [tch_pkg::TMR_W-1:0] cnt_q;
   logic run_q;
   logic done_q;
   logic at_end;

   assign at_end = (cnt_q == '0);
   assign ln.tmr_done = done_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         done_q <= 1'b0;
      end else if (ln.tmr_go) begin
         cnt_q <= tch_pkg::TMR_W'(CYC - 2);
         run_q <= 1'b1;
         done_q <= 1'b0;
      end else begin
         done_q <= run_q & at_end;
         if (at_end) begin
            run_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// File: tch_checker.sv
// Port assertions for the two-wire bus host
`timescale 1ns/100ps
module tch_checker (
   input wire logic clock,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic tx_ready,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic done,
   input wire logic nack,
   input wire logic bus_busy,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   property p_low;
      !scl_o && !sda_o;
   endproperty
   a_low: assert property (p_low) else $error("line driven high");
   property p_rst;
      $past(rst) |-> !cmd_ready && !scl_oe && !sda_oe && !done;
   endproperty
   a_rst: assert property (p_rst) else $error("bus not idle after reset");
   property p_take;
      cmd_valid && cmd_ready |=> !cmd_ready && sda_oe && !scl_oe ##[14:18] scl_oe;
   endproperty
   a_take: assert property (p_take) else $error("start sequence wrong");
   property p_start;
      $rose(sda_oe) && !scl_oe |-> $past(cmd_valid) && $past(cmd_ready);
   endproperty
   a_start: assert property (p_start) else $error("data fell with clock high");
   property p_stop;
      $fell(sda_oe) && !scl_oe |-> ##[10:24] done;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not closing");
   property p_wait;
      !$past(scl_oe) && !scl_oe && !scl_i |=> !scl_oe;
   endproperty
   a_wait: assert property (p_wait) else $error("clock pulled before high");
   property p_done;
      done |-> !bus_busy && !sda_oe && !scl_oe;
   endproperty
   a_done: assert property (p_done) else $error("done with bus held");
   property p_tx;
      tx_ready |-> scl_oe ##1 !tx_ready;
   endproperty
   a_tx: assert property (p_tx) else $error("byte load wrong");
   property p_rx;
      $changed(rx_data) |-> rx_valid;
   endproperty
   a_rx: assert property (p_rx) else $error("read data without pulse");
   property p_nack;
      $rose(nack) |-> ##[16:200] done;
   endproperty
   a_nack: assert property (p_nack) else $error("no stop after nack");
   c_tx: cover property (tx_ready);
   c_rx: cover property (rx_valid);
   c_nack: cover property ($rose(nack));
   c_done: cover property (done && !nack);
endmodule

bind tch_host tch_checker u_chk (
   .clock(clock),
   .rst(rst),
   .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready),
   .tx_ready(tx_ready),
   .rx_valid(rx_valid),
   .rx_data(rx_data),
   .done(done),
   .nack(nack),
   .bus_busy(bus_busy),
   .scl_i(scl_i),
   .scl_o(scl_o),
   .scl_oe(scl_oe),
   .sda_o(sda_o),
   .sda_oe(sda_oe)
);

// File: tch_dev_model.sv
// Behavioural touch controller target on the two-wire bus
`timescale 1ns/100ps
module tch_dev_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2B
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic [15:0] stretch_ns,
   input wire logic [7:0] rd_base,
   output logic scl_low,
   output logic sda_low,
   output logic [7:0] last_wr,
   output int n_wr
);
   logic [7:0] sh;
   logic [7:0] rd_sh;
   logic act;
   logic adr;
   logic rd;
   logic hack;
   int bitn;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      act = 1'b0;
      n_wr = 0;
   end
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         act = 1'b1;
         adr = 1'b1;
         rd = 1'b0;
         bitn = -1;
      end
   end
   always @(posedge sda) begin
      if (scl === 1'b1) begin
         act = 1'b0;
         sda_low = 1'b0;
      end
   end
   always @(posedge scl) begin
      if (act && bitn == 8) hack = sda;
      else if (act) sh = {sh[6:0], sda};
   end
   always @(negedge scl) begin
      if (act) begin
         bitn = bitn + 1;
         if (bitn == 8) begin
            if (adr && sh[7:1] != DEV_ADDR) act = 1'b0;
            else if (adr) begin
               rd = sh[0];
               sda_low = 1'b1;
            end
            else if (!rd) begin
               sda_low = 1'b1;
               last_wr = sh;
               n_wr++;
            end
            else sda_low = 1'b0;
         end else if (bitn == 9) begin
            bitn = 0;
            rd_sh = adr ? rd_base : rd_sh + 8'h01;
            sda_low = rd && (adr || !hack) && !rd_sh[7];
            act = !(rd && !adr && hack);
            adr = 1'b0;
            if (stretch_ns != 16'h0000) begin
               scl_low = 1'b1;
               #(stretch_ns);
               scl_low = 1'b0;
            end
         end else if (rd && !adr) begin
            sda_low = !rd_sh[7 - bitn];
         end
      end
   end
endmodule

// File: tch_tb.sv
// Self-checking bench for the two-wire bus host
`timescale 1ns/100ps
module tb;
   typedef struct packed {
      logic rw;
      logic [7:0] len;
      logic [7:0] base;
      logic [15:0] str;
   } tch_row_t;
   localparam logic [6:0] DEV_ADDR = 7'h2B;
   localparam tch_row_t ROWS [5] = '{
      '{1'b0, 8'h01, 8'hA5, 16'h0000},
      '{1'b0, 8'h03, 8'h3C, 16'h07D0},
      '{1'b1, 8'h01, 8'h5A, 16'h0000},
      '{1'b1, 8'h03, 8'hFE, 16'h05DC},
      '{1'b0, 8'h00, 8'h11, 16'h0000}};
   logic clock, rst, cmd_valid, cmd_rw, tx_valid, cmd_ready, tx_ready, rx_valid;
   logic done, nack, bus_busy, scl_o, scl_oe, sda_o, sda_oe, scl_low, sda_low;
   logic [6:0] dev_addr;
   logic [7:0] cmd_len, tx_data, rx_data, rd_base, last_wr;
   logic [15:0] stretch;
   int n_wr;
   int err_count;
   int cmp_count;
   int hold;
   wire scl = ~(scl_oe | scl_low);
   wire sda = ~(sda_oe | sda_low);
   always #20 clock = ~clock;
   tch_host u_dut (.clock(clock), .rst(rst), .dev_addr(dev_addr), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_rw(cmd_rw), .cmd_len(cmd_len), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
      .done(done), .nack(nack), .bus_busy(bus_busy), .scl_i(scl), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
   tch_dev_model #(.DEV_ADDR(DEV_ADDR)) u_dev (.scl(scl), .sda(sda), .stretch_ns(stretch),
      .rd_base(rd_base), .scl_low(scl_low), .sda_low(sda_low), .last_wr(last_wr), .n_wr(n_wr));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic run_xfer(input tch_row_t r, input logic [6:0] a);
      logic [7:0] cnt;
      logic bad;
      int n;
      int k;
      int wr0;
      logic seen;
      bad = (a != DEV_ADDR);
      seen = 1'b0;
      cnt = (r.len == 8'h00) ? 8'h01 : r.len;
      n = 0;
      k = 0;
      wr0 = n_wr;
      @(negedge clock);
      dev_addr = a;
      cmd_rw = r.rw;
      cmd_len = r.len;
      tx_data = r.base;
      tx_valid = ~r.rw & (hold == 0);
      stretch = r.str;
      rd_base = r.base;
      while (cmd_ready !== 1'b1 && k < 200) begin
         @(negedge clock);
         k++;
      end
      cmd_valid = 1'b1;
      @(negedge clock);
      cmd_valid = 1'b0;
      while (done !== 1'b1 && k < 20000) begin
         @(negedge clock);
         k++;
         if (bus_busy === 1'b1) seen = 1'b1;
         if (hold != 0 && k == hold) begin
            chk("stall_clk", 8'h01, {7'h00, scl_oe});
            chk("stall_bytes", 8'h00, 8'(n));
            tx_valid = ~r.rw;
         end
         if (tx_ready === 1'b1) begin
            n++;
            tx_data = r.base + 8'(n);
         end
         if (rx_valid === 1'b1) begin
            chk("rx_data", r.base + 8'(n), rx_data);
            n++;
         end
      end
      tx_valid = 1'b0;
      chk("done", 8'h01, {7'h00, done});
      chk("nack", {7'h00, bad}, {7'h00, nack});
      chk("count", bad ? 8'h00 : cnt, 8'(n));
      chk("dev_bytes", (bad | r.rw) ? 8'h00 : cnt, 8'(n_wr - wr0));
      chk("bus_busy", 8'h01, {7'h00, seen});
      chk("bus_free", 8'h00, {7'h00, bus_busy});
      if (!bad && !r.rw) chk("dev_last", r.base + cnt - 8'h01, last_wr);
      $display("test rw %b addr %h ended", r.rw, a);
   endtask
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      dev_addr = 7'h00;
      cmd_valid = 1'b0;
      cmd_rw = 1'b0;
      cmd_len = 8'h00;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      stretch = 16'h0000;
      rd_base = 8'h00;
      err_count = 0;
      cmp_count = 0;
      hold = 0;
      repeat (6) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      for (int i = 0; i < 5; i++) run_xfer(ROWS[i], DEV_ADDR);
      run_xfer(ROWS[1], DEV_ADDR + 7'h01);
      hold = 1500;
      run_xfer(ROWS[0], DEV_ADDR);
      hold = 0;
      @(negedge clock);
      rst = 1'b1;
      repeat (6) @(negedge clock);
      chk("reset_out", 8'h03, {2'h0, cmd_ready, scl_oe, sda_oe, done, scl, sda});
      rst = 1'b0;
      $display("test reset ended");
      run_xfer(ROWS[0], DEV_ADDR);
      finish_test();
   end
   initial begin
      #3000000;
      err_count++;
      $display("mismatch watchdog expected 0 seen 1");
      finish_test();
   end
endmodule
